// ### logic/wdgt_pkg.sv
`default_nettype none
package wdgt_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_RELOAD = 32'hffff0360;
  localparam logic [31:0] ADDR_VALUE = 32'hffff0364;
  localparam logic [31:0] ADDR_CTRL = 32'hffff0368;
  localparam logic [31:0] ADDR_CLEAR = 32'hffff036c;

  // reset values
  localparam logic [15:0] RELOAD_RST = 16'h0040;
  localparam logic [15:0] COUNT_RST = 16'h0040;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // writable control bits: 8..5 and 3..0
  localparam logic [15:0] CTRL_WMASK = 16'h01ef;

  // control field positions
  localparam int CTRL_STOP_PD_BIT = 0;
  localparam int CTRL_IRQ_SEL_BIT = 1;
  localparam int CTRL_SCALE_LSB = 2;
  localparam int CTRL_WDOG_BIT = 5;
  localparam int CTRL_PERIODIC_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_UP_BIT = 8;

  // prescaler codes and tick masks
  localparam logic [1:0] SCALE_DIV1 = 2'h0;
  localparam logic [1:0] SCALE_DIV16 = 2'h1;
  localparam logic [1:0] SCALE_DIV256 = 2'h2;
  localparam logic [7:0] MASK_DIV1 = 8'h00;
  localparam logic [7:0] MASK_DIV16 = 8'h0f;
  localparam logic [7:0] MASK_DIV256 = 8'hff;

  // timing: bus clock and low-power oscillator
  localparam int CLK_HZ = 50_000_000;
  localparam int LF_HZ = 32_768;
  localparam int LF_DIV_CYCLES = CLK_HZ / LF_HZ;
  localparam int LF_CNT_W = 16;
  // longest timeout: 65536 * 256 / 32768
  localparam int WDOG_MAX_TIMEOUT_S = 512;

  // control register layout
  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic count_direction;
    logic timer_enable;
    logic periodic_select;
    logic watchdog_mode_enable;
    logic rsvd_4;
    logic [1:0] prescale_select;
    logic expiry_irq_select;
    logic stop_in_powerdown;
  } wdgt_ctrl_s;

  // whole block state
  typedef struct packed {
    wdgt_ctrl_s timer_control;
    logic [15:0] reload_value;
    logic [15:0] current_count;
    logic [7:0] pre_cnt;
    logic [LF_CNT_W-1:0] lf_cnt;
    logic irq_flag;
    logic wdog_reset;
    logic wdog_irq;
    logic ph_valid;
    logic ph_write;
    logic ph_hit;
    logic [1:0] ph_sel;
    logic [31:0] hrdata;
    logic hreadyout;
  } wdgt_state_s;

endpackage : wdgt_pkg
`default_nettype wire

// ### logic/wdgt_timer.sv
// Operation
// RULE_01: two modes, normal timer and watchdog forcing reset unless serviced
// RULE_02: counter reloads on overflow and at once on any refresh write
// RULE_03: normal mode counts 32.768 kHz ticks divided by 1, 16 or 256
// RULE_04: control bit 5 set enters watchdog mode
// RULE_05: watchdog decrements from reload value down to zero
// RULE_06: divide by 256 with full reload gives 512 s timeout
// RULE_07: software keeps timeouts at 30 ms or longer
// RULE_08: at zero, control bit 1 chooses reset or interrupt
// RULE_09: software writes refresh register before zero to restart period
// RULE_10: in watchdog mode reload and control writes ignored until power-on
// RULE_11: other resets leave watchdog mode and count running
// RULE_12: software configures watchdog in its first instructions
// RULE_13: counter stops while debugger holds the core
// RULE_14: counter runs in power-down unless control bit 0 set
// RULE_15: reload and value hold 16 bits; value is read only
// RULE_16: refresh write clears normal interrupt or restarts watchdog period
// RULE_17: bits 3:2 pick prescaler 1, 16, 256; 11 reserved
// RULE_18: bit 1 set gives interrupt at zero, clear gives reset
// RULE_19: bit 7 enable, bit 8 count up, bit 6 periodic
// RULE_20: watchdog always counts down; expiry output is one-cycle pulse
// RULE_21: control reads zero after power-on: disabled, normal, down
`timescale 1ns/1ps
`default_nettype none
module wdgt_timer #(
  parameter int LF_DIV = wdgt_pkg::LF_DIV_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic soft_reset,
  input wire logic debug_halt,
  input wire logic periph_powerdown,
  output logic timer_irq,
  output logic wdog_irq,
  output logic wdog_reset
);

  localparam logic [wdgt_pkg::LF_CNT_W-1:0] LF_LAST =
    wdgt_pkg::LF_CNT_W'(LF_DIV - 1);

  wdgt_pkg::wdgt_state_s st;
  wdgt_pkg::wdgt_state_s nx;
  wdgt_pkg::wdgt_ctrl_s ctl;
  logic lf_tick;
  logic run;
  logic tick;
  logic wd;
  logic ovf;
  logic accept;
  logic wr_now;
  logic [7:0] pmask;

  assign ctl = st.timer_control;
  assign wd = ctl.watchdog_mode_enable;

  // next-state logic for the whole block
  always_comb begin
    nx = st;
    nx.wdog_reset = 1'b0;
    nx.wdog_irq = 1'b0;
    ovf = 1'b0;
    pmask = wdgt_pkg::MASK_DIV1;

    // low-power oscillator rate derived from the bus clock
    lf_tick = (st.lf_cnt == LF_LAST);
    if (lf_tick) begin
      nx.lf_cnt = '0;
    end else begin
      nx.lf_cnt = st.lf_cnt + 1'b1;
    end

    // run gate: enable, debug hold, power-down stop
    run = ctl.timer_enable // [RULE_19]
      & ~debug_halt // [RULE_13]
      & ~(periph_powerdown & ctl.stop_in_powerdown); // [RULE_14]

    // prescaler select, reserved code passes undivided
    if (ctl.prescale_select == wdgt_pkg::SCALE_DIV16) begin
      pmask = wdgt_pkg::MASK_DIV16; // [RULE_17]
    end else if (ctl.prescale_select == wdgt_pkg::SCALE_DIV256) begin
      pmask = wdgt_pkg::MASK_DIV256; // [RULE_06]
    end
    tick = run & lf_tick & ((st.pre_cnt & pmask) == pmask); // [RULE_03]
    if (run & lf_tick) begin
      nx.pre_cnt = st.pre_cnt + 1'b1;
    end

    // counter step
    if (tick) begin
      if (wd) begin
        // watchdog: down only, reload after sitting at zero
        if (st.current_count == 16'h0000) begin
          nx.current_count = st.reload_value; // [RULE_02]
        end else begin
          nx.current_count = st.current_count - 1'b1; // [RULE_05] [RULE_20]
          if (st.current_count == 16'h0001) begin
            // expiry action chosen by bit 1
            nx.wdog_irq = ctl.expiry_irq_select; // [RULE_08] [RULE_18]
            nx.wdog_reset = ~ctl.expiry_irq_select; // [RULE_01] [RULE_20]
          end
        end
      end else if (ctl.count_direction) begin
        if (st.current_count == 16'hffff) begin
          ovf = 1'b1;
          nx.current_count = ctl.periodic_select ?
            st.reload_value : 16'h0000; // [RULE_19] [RULE_02]
        end else begin
          nx.current_count = st.current_count + 1'b1;
        end
      end else begin
        if (st.current_count == 16'h0000) begin
          ovf = 1'b1;
          nx.current_count = ctl.periodic_select ?
            st.reload_value : 16'hffff; // [RULE_19] [RULE_02]
        end else begin
          nx.current_count = st.current_count - 1'b1;
        end
      end
    end

    // address phase capture and read data
    accept = hsel & hready & htrans[1];
    nx.ph_valid = accept;
    nx.ph_write = hwrite;
    nx.ph_hit = 1'b1;
    nx.ph_sel = 2'h0;
    if (haddr == wdgt_pkg::ADDR_RELOAD) begin
      nx.ph_sel = 2'h0;
    end else if (haddr == wdgt_pkg::ADDR_VALUE) begin
      nx.ph_sel = 2'h1;
    end else if (haddr == wdgt_pkg::ADDR_CTRL) begin
      nx.ph_sel = 2'h2;
    end else if (haddr == wdgt_pkg::ADDR_CLEAR) begin
      nx.ph_sel = 2'h3;
    end else begin
      nx.ph_hit = 1'b0;
    end
    if (accept & ~hwrite) begin
      nx.hrdata = 32'h0000_0000;
      if (nx.ph_hit) begin
        case (nx.ph_sel)
          2'h0: nx.hrdata = {16'h0000, st.reload_value}; // [RULE_15]
          2'h1: nx.hrdata = {16'h0000, st.current_count}; // [RULE_15]
          2'h2: nx.hrdata = {16'h0000, st.timer_control};
          default: nx.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // data phase writes
    wr_now = st.ph_valid & st.ph_write & st.ph_hit;
    if (wr_now) begin
      case (st.ph_sel)
        2'h0: begin
          if (!wd) begin
            nx.reload_value = hwdata[15:0]; // [RULE_10] [RULE_15]
          end
        end
        2'h2: begin
          if (!wd) begin
            // bit 5 latches watchdog mode until power-on
            nx.timer_control = hwdata[15:0] & wdgt_pkg::CTRL_WMASK; // [RULE_04] [RULE_10]
          end
        end
        2'h3: begin
          nx.current_count = st.reload_value; // [RULE_02] [RULE_16]
          nx.pre_cnt = 8'h00;
          nx.irq_flag = 1'b0; // [RULE_16]
          // a refresh landing on the final step cancels the expiry
          nx.wdog_reset = 1'b0; // [RULE_16]
          nx.wdog_irq = 1'b0;
        end
        default: begin
          nx.reload_value = st.reload_value; // value register is read only
        end
      endcase
    end

    // overflow sets the interrupt, winning over a refresh clear
    if (ovf) begin
      nx.irq_flag = 1'b1;
    end

    // non-power-on reset: ignored once watchdog mode bit 5 is set
    if (soft_reset & ~wd) begin // [RULE_11]
      nx.timer_control = wdgt_pkg::CTRL_RST;
      nx.reload_value = wdgt_pkg::RELOAD_RST;
      nx.current_count = wdgt_pkg::COUNT_RST;
      nx.pre_cnt = 8'h00;
      nx.irq_flag = 1'b0;
    end
    nx.hreadyout = 1'b1;
  end

  // state register, hresetn is the power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.timer_control <= wdgt_pkg::CTRL_RST; // [RULE_21]
      st.reload_value <= wdgt_pkg::RELOAD_RST;
      st.current_count <= wdgt_pkg::COUNT_RST;
      st.hreadyout <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from state, except hresp which is tied low
  assign hreadyout = st.hreadyout;
  assign hrdata = st.hrdata;
  assign hresp = 1'b0; // always OKAY
  assign timer_irq = st.irq_flag;
  assign wdog_irq = st.wdog_irq;
  assign wdog_reset = st.wdog_reset;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_refresh_reload;
    wr_now && st.ph_sel == 2'h3 && !(soft_reset && !wd)
      |=> st.current_count == $past(st.reload_value);
  endproperty
  a_refresh_reload: assert property (p_refresh_reload) // [RULE_02]
    else $error("refresh write did not reload counter");

  property p_wdog_down;
    wd && tick && st.current_count != 16'h0000 && !wr_now
      |=> st.current_count == $past(st.current_count) - 16'h0001;
  endproperty
  a_wdog_down: assert property (p_wdog_down) // [RULE_05]
    else $error("watchdog did not decrement by one");

  property p_protect;
    wd && wr_now && st.ph_sel != 2'h3
      |=> $stable(st.timer_control) && $stable(st.reload_value);
  endproperty
  a_protect: assert property (p_protect) // [RULE_10]
    else $error("protected register changed in watchdog mode");

  property p_reset_sel;
    wdog_reset |-> !ctl.expiry_irq_select && $past(st.current_count) == 16'h0001;
  endproperty
  a_reset_sel: assert property (p_reset_sel) // [RULE_18]
    else $error("watchdog reset without expiry or with irq selected");

  property p_irq_sel;
    wdog_irq |-> ctl.expiry_irq_select && st.current_count == 16'h0000;
  endproperty
  a_irq_sel: assert property (p_irq_sel) // [RULE_08]
    else $error("watchdog irq without expiry or with reset selected");

  property p_pulse;
    (wdog_reset || wdog_irq) |=> !wdog_reset && !wdog_irq;
  endproperty
  a_pulse: assert property (p_pulse) // [RULE_20]
    else $error("expiry output longer than one cycle");

  property p_halt;
    debug_halt && !wr_now && !soft_reset |=> $stable(st.current_count);
  endproperty
  a_halt: assert property (p_halt) // [RULE_13]
    else $error("counter moved during debug hold");

  property p_pd_stop;
    periph_powerdown && ctl.stop_in_powerdown && !wr_now && !soft_reset
      |=> $stable(st.current_count);
  endproperty
  a_pd_stop: assert property (p_pd_stop) // [RULE_14]
    else $error("counter moved in power-down with stop set");

  property p_soft_keep;
    wd && soft_reset |=> wd;
  endproperty
  a_soft_keep: assert property (p_soft_keep) // [RULE_11]
    else $error("other reset left watchdog mode");

  property p_div1;
    run && lf_tick && ctl.prescale_select == wdgt_pkg::SCALE_DIV1 |-> tick;
  endproperty
  a_div1: assert property (p_div1) // [RULE_17]
    else $error("undivided prescaler missed a tick");

  property p_ovf_irq;
    ovf && !soft_reset |=> timer_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) // [RULE_16]
    else $error("overflow did not raise the timer interrupt");

  property p_refresh_cancels;
    wd && wr_now && st.ph_sel == 2'h3 |=> !wdog_reset && !wdog_irq;
  endproperty
  a_refresh_cancels: assert property (p_refresh_cancels) // [RULE_16]
    else $error("refresh write did not cancel the expiry");

  property p_irq_clear;
    wr_now && st.ph_sel == 2'h3 && !ovf |=> !timer_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // [RULE_16]
    else $error("refresh write did not clear the timer interrupt");

  property p_soft_restore;
    soft_reset && !wd
      |=> st.timer_control == wdgt_pkg::CTRL_RST
        && st.reload_value == wdgt_pkg::RELOAD_RST
        && st.current_count == wdgt_pkg::COUNT_RST;
  endproperty
  a_soft_restore: assert property (p_soft_restore) // [RULE_11]
    else $error("other reset did not restore the timer registers");

  property p_value_ro;
    wr_now && st.ph_sel == 2'h1 && !tick && !soft_reset
      |=> $stable(st.current_count);
  endproperty
  a_value_ro: assert property (p_value_ro) // [RULE_15]
    else $error("write changed the read-only count");

  property p_wd_enter;
    !wd && wr_now && st.ph_sel == 2'h2 && !soft_reset
      |=> wd == $past(hwdata[wdgt_pkg::CTRL_WDOG_BIT]);
  endproperty
  a_wd_enter: assert property (p_wd_enter) // [RULE_04]
    else $error("control bit 5 did not set watchdog mode");

  property p_disabled_hold;
    !ctl.timer_enable && !wr_now && !soft_reset
      |=> $stable(st.current_count);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) // [RULE_19]
    else $error("counter moved while disabled");

  c_wdog_reset: cover property (wdog_reset);
  c_wdog_irq: cover property (wdog_irq);
  c_refresh_in_wd: cover property (wd && wr_now && st.ph_sel == 2'h3);
  c_normal_ovf: cover property (ovf && !wd);

endmodule : wdgt_timer
`default_nettype wire

// ### testbench/wdgt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wdgt_timer_bench;
  localparam int DIV = 4;
  localparam logic [31:0] A_LD = wdgt_pkg::ADDR_RELOAD;
  localparam logic [31:0] A_VAL = wdgt_pkg::ADDR_VALUE;
  localparam logic [31:0] A_CON = wdgt_pkg::ADDR_CTRL;
  localparam logic [31:0] A_CLR = wdgt_pkg::ADDR_CLEAR;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rd2;
  logic [1:0] htrans;
  logic soft_reset, debug_halt, periph_powerdown;
  logic timer_irq, wdog_irq, wdog_reset;
  int n_errors, total_checks;
  int n_rst = 0;
  int n_irq = 0;

  // 50 mhz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  wdgt_timer #(.LF_DIV(DIV)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .soft_reset(soft_reset), .debug_halt(debug_halt),
    .periph_powerdown(periph_powerdown), .timer_irq(timer_irq),
    .wdog_irq(wdog_irq), .wdog_reset(wdog_reset));

  // expiry pulse counters
  always @(posedge hclk) begin
    if (wdog_reset === 1'b1) n_rst <= n_rst + 1;
    if (wdog_irq === 1'b1) n_irq <= n_irq + 1;
  end

  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // bounded wait for hready at a rising edge
  task wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: bus hang", $time);
      conclude();
    end
  endtask : wait_ready

  // one single word transfer, address phase then data phase
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
           output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    d = hrdata;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rdr(input logic [31:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask : rdr

  task por;
    hresetn <= 1'b0;
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
  endtask : por

  task pulse_soft;
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
  endtask : pulse_soft

  // reset values, read-only and reserved places
  task t_regs;
    rdr(A_LD, rd); check(rd, 32'h40, "reload reset");
    rdr(A_VAL, rd); check(rd, 32'h40, "count reset");
    rdr(A_CON, rd); check(rd, 32'h0, "control reset");
    wr(A_VAL, 32'h1234);
    rdr(A_VAL, rd); check(rd, 32'h40, "value write");
    wr(A_CON, 32'hfe10);
    rdr(A_CON, rd); check(rd, 32'h0, "reserved bits");
    wr(32'hffff0370, 32'h55);
    rdr(32'hffff0370, rd); check(rd, 32'h0, "unmapped");
    check(32'(hresp), 32'h0, "okay response");
    wr(A_LD, 32'hffff1234);
    rdr(A_LD, rd); check(rd, 32'h1234, "reload width");
    pulse_soft();
    rdr(A_LD, rd); check(rd, 32'h40, "soft reset normal");
  endtask : t_regs

  // normal down count, overflow flag and refresh clear
  task t_norm(input logic per);
    int i;
    wr(A_LD, 32'h3);
    wr(A_CLR, 32'h0);
    wr(A_CON, per ? 32'hc0 : 32'h80);
    i = 0;
    while (timer_irq !== 1'b1 && i < 60) begin
      @(posedge hclk);
      i++;
    end
    if (timer_irq !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: no overflow seen", $time);
      conclude();
    end
    check(32'(i >= 10 && i <= 22), 32'h1, "overflow time");
    rdr(A_VAL, rd);
    check(32'(per ? rd <= 3 : rd >= 32'hfff0), 32'h1, "wrap");
    wr(A_CLR, 32'h0);
    @(posedge hclk);
    check(32'(timer_irq), 32'h0, "irq clear");
    wr(A_CON, 32'h0);
    wr(A_CLR, 32'h0);
  endtask : t_norm

  // prescaler codes: no step before for 16 and 256, a step after for all three
  task t_scale;
    int lo[3];
    int hi[3];
    lo = '{0, 40, 900};
    hi = '{8, 40, 200};
    wr(A_LD, 32'h100);
    for (int s = 0; s < 3; s++) begin
      wr(A_CON, 32'h80 | (s << 2));
      wr(A_CLR, 32'h0);
      cyc(lo[s]);
      rdr(A_VAL, rd);
      if (s > 0) check(rd, 32'h100, "early step");
      cyc(hi[s]);
      rdr(A_VAL, rd); check(32'(rd < 32'h100), 32'h1, "step");
    end
    wr(A_CON, 32'h0);
  endtask : t_scale

  // debug halt and power-down freeze
  task t_freeze;
    logic [31:0] c[3];
    logic dh[3];
    logic fz[3];
    c = '{32'h80, 32'h81, 32'h80};
    dh = '{1'b1, 1'b0, 1'b0};
    fz = '{1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 3; k++) begin
      debug_halt <= dh[k];
      periph_powerdown <= ~dh[k];
      wr(A_CON, c[k]);
      rdr(A_VAL, rd);
      cyc(20);
      rdr(A_VAL, rd2);
      check(32'(rd === rd2), 32'(fz[k]), "freeze");
    end
    debug_halt <= 1'b0;
    periph_powerdown <= 1'b0;
    wr(A_CON, 32'h0);
  endtask : t_freeze

  task t_up;
    wr(A_LD, 32'h3);
    wr(A_CLR, 32'h0);
    wr(A_CON, 32'h180);
    rdr(A_VAL, rd);
    cyc(20);
    rdr(A_VAL, rd2);
    check(32'(rd2 > rd), 32'h1, "count up");
    wr(A_CON, 32'h0);
  endtask : t_up

  // watchdog: service, lock, other reset, expiry kind and width
  task t_wdog(input logic irqsel);
    int i, r0, q0;
    logic [31:0] c;
    c = irqsel ? 32'h1a2 : 32'h1a0;
    por();
    // configured first thing, short timeout for the shrunken divider
    wr(A_LD, 32'h5);
    wr(A_CLR, 32'h0);
    wr(A_CON, c);
    r0 = n_rst;
    q0 = n_irq;
    repeat (6) begin
      cyc(8);
      wr(A_CLR, 32'hff);
    end
    check(n_rst + n_irq - r0 - q0, 32'h0, "serviced");
    wr(A_LD, 32'h20);
    wr(A_CON, 32'h0);
    rdr(A_LD, rd); check(rd, 32'h5, "reload locked");
    rdr(A_CON, rd); check(rd, c, "control locked");
    pulse_soft();
    rdr(A_CON, rd); check(rd, c, "soft reset kept");
    wr(A_CLR, 32'h0);
    r0 = n_rst;
    q0 = n_irq;
    i = 0;
    while ((wdog_reset | wdog_irq) !== 1'b1 && i < 60) begin
      @(posedge hclk);
      i++;
    end
    if ((wdog_reset | wdog_irq) !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: no watchdog expiry seen", $time);
      conclude();
    end
    check(32'(i >= 16 && i <= 26), 32'h1, "expiry time");
    @(posedge hclk);
    check(32'(wdog_reset | wdog_irq), 32'h0, "width");
    cyc(1);
    check(n_irq - q0, 32'(irqsel), "irq kind");
    check(n_rst - r0, 32'(!irqsel), "reset kind");
  endtask : t_wdog

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    soft_reset = 1'b0;
    debug_halt = 1'b0;
    periph_powerdown = 1'b0;
    n_errors = 0;
    total_checks = 0;
    por();
    t_regs();
    t_norm(1'b1);
    t_norm(1'b0);
    t_scale();
    t_freeze();
    t_up();
    t_wdog(1'b0);
    t_wdog(1'b1);
    conclude();
  end
endmodule : wdgt_timer_bench
`default_nettype wire
